//--- bench/gpio_ports_properties.sv
// Concurrent checks on the port block's bus and pins
`timescale 1ns/1ps
module gpio_ports_checker (
  input logic aclk,
  input logic aresetn,
  input logic [7:0] awaddr,
  input logic awvalid,
  input logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  input logic wready,
  input logic [7:0] araddr,
  input logic arvalid,
  input logic arready,
  input logic [31:0] rdata,
  input logic [1:0] rresp,
  input logic [7:0] wide_port_pin_level,
  input logic [7:0] wide_port_pin_drive,
  input logic [7:0] wide_port_pin_enable,
  input logic [3:0] narrow_port_pin_level,
  input logic [3:0] narrow_port_pin_enable,
  input logic external_interrupt_line_four_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence write_to(logic [7:0] a);
    awvalid && awready && wvalid && wready && wstrb[0] && awaddr == a;
  endsequence
  sequence read_of(logic [7:0] a);
    arvalid && arready && araddr == a;
  endsequence
  // Synchroniser needs the level held over three edges
  sequence wide_steady;
    $stable(wide_port_pin_level) [*3];
  endsequence
  property reg_to_pins(logic [7:0] a, logic [7:0] pins);
    write_to(a) |=> ##1 pins == $past(wdata[7:0], 2);
  endproperty
  property reads_ones(logic [7:0] a);
    read_of(a) |=> rdata[7:0] == 8'hFF;
  endproperty
  wide_enable_a: assert property (reg_to_pins(gpio_pkg::WIDE_DIRECTION_OFFSET, wide_port_pin_enable))
    else $error("wide enable differs from direction written");
  wide_drive_a: assert property (reg_to_pins(gpio_pkg::WIDE_DATA_OFFSET, wide_port_pin_drive))
    else $error("wide drive differs from data written");
  wide_read_a: assert property (wide_steady ##0 read_of(gpio_pkg::WIDE_DATA_OFFSET) |=>
    (((rdata[7:0] ^ $past(wide_port_pin_drive)) & $past(wide_port_pin_enable)) |
    ((rdata[7:0] ^ $past(wide_port_pin_level)) & ~$past(wide_port_pin_enable))) == 8'h00)
    else $error("wide read mixes latch and pins wrongly");
  wide_dir_ones_a: assert property (reads_ones(gpio_pkg::WIDE_DIRECTION_OFFSET))
    else $error("wide direction read not all ones");
  narrow_dir_ones_a: assert property (reads_ones(gpio_pkg::NARROW_DIRECTION_OFFSET))
    else $error("narrow direction read not all ones");
  narrow_upper_a: assert property (arvalid && arready && (araddr == gpio_pkg::NARROW_DATA_OFFSET ||
    araddr == gpio_pkg::NARROW_FUNCTION_SELECT_OFFSET) |=> rdata[7:4] == 4'hF)
    else $error("narrow upper bits not ones");
  irq_fall_a: assert property ($fell(external_interrupt_line_four_n) |->
    !narrow_port_pin_enable[2] && !$past(narrow_port_pin_level[2], 3))
    else $error("interrupt line fell without low input pin");
  slave_error_a: assert property (arvalid && arready && araddr >= 8'h18 |=>
    rresp == gpio_pkg::RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule // gpio_ports_checker
bind gpio_ports gpio_ports_checker gpio_ports_checker_inst (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .wide_port_pin_level(wide_port_pin_level), .wide_port_pin_drive(wide_port_pin_drive),
  .wide_port_pin_enable(wide_port_pin_enable), .narrow_port_pin_level(narrow_port_pin_level),
  .narrow_port_pin_enable(narrow_port_pin_enable),
  .external_interrupt_line_four_n(external_interrupt_line_four_n)
);

//--- bench/pin_board.sv
// Board model that resolves pin levels from the device and outside sources
`timescale 1ns/1ps
module pin_board (
  input logic [7:0] wide_drive,
  input logic [7:0] wide_enable,
  input logic [7:0] wide_outside,
  input logic [3:0] narrow_drive,
  input logic [3:0] narrow_enable,
  input logic [3:0] narrow_outside,
  output logic [7:0] wide_level,
  output logic [3:0] narrow_level
);
  // Released pins take the board source, so a stale drive value never leaks back
  assign wide_level = (wide_drive & wide_enable) | (wide_outside & ~wide_enable);
  assign narrow_level = (narrow_drive & narrow_enable) | (narrow_outside & ~narrow_enable);
endmodule // pin_board

//--- bench/tb_gpio_ports.sv
// Self-checking bench for the two I/O ports
`timescale 1ns/1ps
module tb_gpio_ports;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, wide_outside = 8'h5A, wide_level;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] narrow_outside = 4'hC, narrow_level;
  logic pulse_output_one = 1'b0, pulse_output_two = 1'b0;
  logic pulse_output_three = 1'b0, pulse_output_four = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, external_interrupt_line_four_n;
  logic [1:0] bresp, rresp;
  logic [7:0] wide_port_pin_drive, wide_port_pin_enable;
  logic [3:0] narrow_port_pin_drive, narrow_port_pin_enable;
  logic [15:0] tick = 16'h0000;
  int bad_count = 0;
  int n_compared = 0;
  gpio_ports gpio_ports_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wide_port_pin_level(wide_level), .wide_port_pin_drive(wide_port_pin_drive),
    .wide_port_pin_enable(wide_port_pin_enable), .narrow_port_pin_level(narrow_level),
    .narrow_port_pin_drive(narrow_port_pin_drive), .narrow_port_pin_enable(narrow_port_pin_enable),
    .pulse_output_one(pulse_output_one), .pulse_output_two(pulse_output_two),
    .pulse_output_three(pulse_output_three), .pulse_output_four(pulse_output_four),
    .external_interrupt_line_four_n(external_interrupt_line_four_n)
  );
  pin_board pin_board_inst (
    .wide_drive(wide_port_pin_drive), .wide_enable(wide_port_pin_enable), .wide_outside(wide_outside),
    .narrow_drive(narrow_port_pin_drive), .narrow_enable(narrow_port_pin_enable),
    .narrow_outside(narrow_outside), .wide_level(wide_level), .narrow_level(narrow_level)
  );
  initial begin
    forever #25 aclk = ~aclk;
  end
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // A hung handshake ends here instead of running forever
  always @(posedge aclk) begin
    tick <= tick + 16'h0001;
    if (tick == 16'h0BB8) begin
      bad_count++;
      final_report();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    check("write resp", bresp, er);
  endtask
  task automatic bus_read(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    check("read data", rdata, exp);
    check("read resp", rresp, er);
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    cycles(2);
    check("wide enable", wide_port_pin_enable, 32'h0);
    check("narrow enable", narrow_port_pin_enable, 32'h0);
    check("irq idle", external_interrupt_line_four_n, 32'h1);
    bus_read(gpio_pkg::NARROW_FUNCTION_SELECT_OFFSET, 32'hF0);
    $display("test reset done");
    bus_write(gpio_pkg::WIDE_DIRECTION_OFFSET, 8'hA5);
    check("wide enable", wide_port_pin_enable, 32'hA5);
    bus_write(gpio_pkg::WIDE_DATA_OFFSET, 8'h3C);
    check("wide drive", wide_port_pin_drive, 32'h3C);
    bus_read(gpio_pkg::WIDE_DATA_OFFSET, 32'h7E);
    bus_read(gpio_pkg::WIDE_DIRECTION_OFFSET, 32'hFF);
    wide_outside <= 8'h00;
    cycles(4);
    bus_read(gpio_pkg::WIDE_DATA_OFFSET, 32'h24);
    $display("test wide done");
    bus_write(gpio_pkg::NARROW_DIRECTION_OFFSET, 8'hF5);
    bus_write(gpio_pkg::NARROW_DATA_OFFSET, 8'h0A);
    check("narrow enable", narrow_port_pin_enable, 32'h5);
    check("narrow drive", narrow_port_pin_drive & 4'h5, 32'h0);
    bus_read(gpio_pkg::NARROW_DATA_OFFSET, 32'hF8);
    bus_read(gpio_pkg::NARROW_DIRECTION_OFFSET, 32'hFF);
    bus_write(gpio_pkg::NARROW_FUNCTION_SELECT_OFFSET, 8'h03);
    bus_read(gpio_pkg::NARROW_FUNCTION_SELECT_OFFSET, 32'hF3);
    pulse_output_one <= 1'b1;
    cycles(2);
    check("pulse pins", {narrow_port_pin_enable[1:0], narrow_port_pin_drive[1:0]}, 32'hD);
    pulse_output_one <= 1'b0;
    pulse_output_two <= 1'b1;
    cycles(2);
    check("pulse drive", narrow_port_pin_drive[1:0], 32'h2);
    $display("test narrow done");
    bus_write(gpio_pkg::NARROW_DIRECTION_OFFSET, 8'h00);
    bus_write(gpio_pkg::NARROW_FUNCTION_SELECT_OFFSET, 8'h04);
    narrow_outside <= 4'h0;
    cycles(5);
    check("irq low", {external_interrupt_line_four_n, narrow_port_pin_enable[2]}, 32'h0);
    bus_write(gpio_pkg::EXTERNAL_FUNCTION_CONTROL_OFFSET, 8'h01);
    check("pin two enable", narrow_port_pin_enable[2], 32'h0);
    narrow_outside <= 4'h4;
    cycles(5);
    check("irq high", external_interrupt_line_four_n, 32'h1);
    bus_write(gpio_pkg::NARROW_FUNCTION_SELECT_OFFSET, 8'h00);
    bus_write(gpio_pkg::EXTERNAL_FUNCTION_CONTROL_OFFSET, 8'h03);
    pulse_output_three <= 1'b1;
    cycles(2);
    check("alt pins", {narrow_port_pin_enable[3:2], narrow_port_pin_drive[3:2]}, 32'hD);
    ce <= 1'b0;
    pulse_output_three <= 1'b0;
    cycles(3);
    check("frozen drive", narrow_port_pin_drive[2], 32'h1);
    ce <= 1'b1;
    cycles(2);
    check("thawed drive", narrow_port_pin_drive[2], 32'h0);
    $display("test alternate done");
    bus_read(8'h20, 32'h0, gpio_pkg::RESP_SLVERR);
    bus_write(8'h20, 8'h55, gpio_pkg::RESP_SLVERR);
    $display("test unmapped done");
    final_report();
  end
endmodule // tb_gpio_ports

//--- logic/gpio_pkg.sv
// Shared constants and types for the two general purpose I/O ports
package gpio_pkg;

  localparam int WIDE_WIDTH = 8;
  localparam int NARROW_WIDTH = 4;
  localparam int ADDR_WIDTH = 8;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] WIDE_DATA_OFFSET = 8'h00;
  localparam logic [7:0] WIDE_DIRECTION_OFFSET = 8'h04;
  localparam logic [7:0] NARROW_DATA_OFFSET = 8'h08;
  localparam logic [7:0] NARROW_DIRECTION_OFFSET = 8'h0C;
  localparam logic [7:0] NARROW_FUNCTION_SELECT_OFFSET = 8'h10;
  localparam logic [7:0] EXTERNAL_FUNCTION_CONTROL_OFFSET = 8'h14;

  // Reset values
  localparam logic [7:0] WIDE_DATA_RESET = 8'h00;
  localparam logic [7:0] WIDE_DIRECTION_RESET = 8'h00;
  localparam logic [3:0] NARROW_DATA_RESET = 4'hF;
  localparam logic [3:0] NARROW_DIRECTION_RESET = 4'h0;
  localparam logic [3:0] NARROW_FUNCTION_SELECT_RESET = 4'h0;
  localparam logic [1:0] EXTERNAL_FUNCTION_CONTROL_RESET = 2'h0;

  // Read-back constants
  localparam logic [7:0] WRITE_ONLY_READ_VALUE = 8'hFF;
  localparam logic [3:0] NARROW_UPPER_READ_VALUE = 4'hF;

  // Field positions in the narrow port function select register
  localparam int SELECT_PULSE_ONE_BIT = 0;
  localparam int SELECT_PULSE_TWO_BIT = 1;
  localparam int SELECT_INTERRUPT_BIT = 2;
  localparam int SELECT_RESERVED_BIT = 3;

  // Field positions in the external function control register
  localparam int CONTROL_PULSE_THREE_BIT = 0;
  localparam int CONTROL_PULSE_FOUR_BIT = 1;

  // Narrow port pin roles
  localparam int NARROW_INTERRUPT_PIN = 2;
  localparam int NARROW_PULSE_THREE_PIN = 2;
  localparam int NARROW_PULSE_FOUR_PIN = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_WIDE_DATA = 3'h1,
    SEL_WIDE_DIRECTION = 3'h3,
    SEL_NARROW_DATA = 3'h2,
    SEL_NARROW_DIRECTION = 3'h6,
    SEL_NARROW_FUNCTION_SELECT = 3'h7,
    SEL_EXTERNAL_FUNCTION_CONTROL = 3'h5
  } reg_sel_type;

endpackage

//--- logic/gpio_ports.sv
// Wide and narrow general purpose I/O ports with AXI4-Lite register access
`timescale 1ns/1ps
module gpio_ports (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] wide_port_pin_level,
  output logic [7:0] wide_port_pin_drive,
  output logic [7:0] wide_port_pin_enable,
  input wire logic [3:0] narrow_port_pin_level,
  output logic [3:0] narrow_port_pin_drive,
  output logic [3:0] narrow_port_pin_enable,
  input wire logic pulse_output_one,
  input wire logic pulse_output_two,
  input wire logic pulse_output_three,
  input wire logic pulse_output_four,
  output logic external_interrupt_line_four_n
);

  localparam int WW = gpio_pkg::WIDE_WIDTH;
  localparam int NW = gpio_pkg::NARROW_WIDTH;

  typedef struct packed {
    // Bus handshake state
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    // Registers software can write
    logic [WW-1:0] wide_data;
    logic [WW-1:0] wide_dir;
    logic [NW-1:0] narrow_data;
    logic [NW-1:0] narrow_dir;
    logic [NW-1:0] select;
    logic [1:0] control;
    // Pin controls, registered so outputs come from flops
    logic [WW-1:0] wide_drive;
    logic [WW-1:0] wide_enable;
    logic [NW-1:0] narrow_drive;
    logic [NW-1:0] narrow_enable;
    logic irq_n;
  } state_type;

  localparam state_type RESET_STATE = '{
    // Bus idle and ready for the first request
    awready: 1'b1,
    wready: 1'b1,
    aw_got: 1'b0,
    w_got: 1'b0,
    waddr: 8'h00,
    wbyte: 8'h00,
    wlane: 1'b0,
    bvalid: 1'b0,
    bresp: gpio_pkg::RESP_OKAY,
    arready: 1'b1,
    rvalid: 1'b0,
    rresp: gpio_pkg::RESP_OKAY,
    rdata: 32'h0000_0000,
    // Every pin starts as an input
    wide_data: gpio_pkg::WIDE_DATA_RESET,
    wide_dir: gpio_pkg::WIDE_DIRECTION_RESET,
    narrow_data: gpio_pkg::NARROW_DATA_RESET,
    narrow_dir: gpio_pkg::NARROW_DIRECTION_RESET,
    select: gpio_pkg::NARROW_FUNCTION_SELECT_RESET,
    control: gpio_pkg::EXTERNAL_FUNCTION_CONTROL_RESET,
    // Pin controls mirror the register resets
    wide_drive: gpio_pkg::WIDE_DATA_RESET,
    wide_enable: gpio_pkg::WIDE_DIRECTION_RESET,
    narrow_drive: gpio_pkg::NARROW_DATA_RESET,
    narrow_enable: gpio_pkg::NARROW_DIRECTION_RESET,
    irq_n: 1'b1
  };

  state_type q;
  state_type d;

  pin_sync_if #(.WIDTH(WW + NW)) pins ();

  assign pins.raw = {narrow_port_pin_level, wide_port_pin_level};

  pin_sync #(
    .WIDTH(WW + NW)
  ) u_pin_sync (
    .aclk(aclk),
    .ce(ce),
    .aresetn(aresetn),
    .pins(pins.syncer)
  );

  // Shared by the read and write paths
  function automatic gpio_pkg::reg_sel_type decode(input logic [7:0] addr);
    gpio_pkg::reg_sel_type sel;
    sel = gpio_pkg::SEL_NONE;
    case (addr)
      gpio_pkg::WIDE_DATA_OFFSET: sel = gpio_pkg::SEL_WIDE_DATA;
      gpio_pkg::WIDE_DIRECTION_OFFSET: sel = gpio_pkg::SEL_WIDE_DIRECTION;
      gpio_pkg::NARROW_DATA_OFFSET: sel = gpio_pkg::SEL_NARROW_DATA;
      gpio_pkg::NARROW_DIRECTION_OFFSET: sel = gpio_pkg::SEL_NARROW_DIRECTION;
      gpio_pkg::NARROW_FUNCTION_SELECT_OFFSET: sel = gpio_pkg::SEL_NARROW_FUNCTION_SELECT;
      gpio_pkg::EXTERNAL_FUNCTION_CONTROL_OFFSET: sel = gpio_pkg::SEL_EXTERNAL_FUNCTION_CONTROL;
      default: sel = gpio_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction

  logic [WW-1:0] wide_level;
  logic [NW-1:0] narrow_level;
  logic [WW-1:0] wide_read;
  logic [NW-1:0] narrow_read;
  logic [7:0] read_byte;
  logic read_hit;
  gpio_pkg::reg_sel_type read_sel;
  gpio_pkg::reg_sel_type write_sel;
  logic irq_mode;
  logic pulse_three_mode;
  logic pulse_four_mode;

  assign wide_level = pins.synced[WW-1:0];
  assign narrow_level = pins.synced[WW+NW-1:WW];
  assign read_sel = decode(araddr);
  assign write_sel = decode(q.waddr);

  // Per-bit read mux: latch for outputs, pin for inputs
  genvar gi;
  generate
    for (gi = 0; gi < WW; gi++) begin : g_wide_read
      assign wide_read[gi] = q.wide_dir[gi] ? q.wide_data[gi] : wide_level[gi];
    end
    for (gi = 0; gi < NW; gi++) begin : g_narrow_read
      assign narrow_read[gi] = q.narrow_dir[gi] ? q.narrow_data[gi] : narrow_level[gi];
    end
  endgenerate

  always_comb begin
    read_byte = 8'h00;
    read_hit = 1'b1;
    unique case (read_sel)
      gpio_pkg::SEL_WIDE_DATA: begin
        read_byte = wide_read;
      end
      gpio_pkg::SEL_WIDE_DIRECTION: begin
        read_byte = gpio_pkg::WRITE_ONLY_READ_VALUE;
      end
      gpio_pkg::SEL_NARROW_DATA: begin
        read_byte = {gpio_pkg::NARROW_UPPER_READ_VALUE, narrow_read};
      end
      gpio_pkg::SEL_NARROW_DIRECTION: begin
        read_byte = gpio_pkg::WRITE_ONLY_READ_VALUE;
      end
      gpio_pkg::SEL_NARROW_FUNCTION_SELECT: begin
        read_byte = {gpio_pkg::NARROW_UPPER_READ_VALUE, q.select};
      end
      gpio_pkg::SEL_EXTERNAL_FUNCTION_CONTROL: begin
        read_byte = {6'h00, q.control};
      end
      gpio_pkg::SEL_NONE: begin
        read_hit = 1'b0;
      end
    endcase
  end

  // Interrupt use of pin 2 outranks pulse output three
  assign irq_mode = q.select[gpio_pkg::SELECT_INTERRUPT_BIT];
  assign pulse_three_mode = q.control[gpio_pkg::CONTROL_PULSE_THREE_BIT] && !irq_mode;
  assign pulse_four_mode = q.control[gpio_pkg::CONTROL_PULSE_FOUR_BIT];

  always_comb begin
    d = q;

    // Write address and data are taken independently
    if (q.awready && awvalid) begin
      d.aw_got = 1'b1;
      d.awready = 1'b0;
      d.waddr = awaddr;
    end
    if (q.wready && wvalid) begin
      d.w_got = 1'b1;
      d.wready = 1'b0;
      d.wbyte = wdata[7:0];
      d.wlane = wstrb[0];
    end

    // Only byte lane 0 holds register bits
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = gpio_pkg::RESP_OKAY;
      unique case (write_sel)
        gpio_pkg::SEL_WIDE_DATA: begin
          if (q.wlane) begin
            d.wide_data = q.wbyte;
          end
        end
        gpio_pkg::SEL_WIDE_DIRECTION: begin
          if (q.wlane) begin
            d.wide_dir = q.wbyte;
          end
        end
        gpio_pkg::SEL_NARROW_DATA: begin
          if (q.wlane) begin
            d.narrow_data = q.wbyte[NW-1:0];
          end
        end
        gpio_pkg::SEL_NARROW_DIRECTION: begin
          if (q.wlane) begin
            d.narrow_dir = q.wbyte[NW-1:0];
          end
        end
        gpio_pkg::SEL_NARROW_FUNCTION_SELECT: begin
          if (q.wlane) begin
            d.select = q.wbyte[NW-1:0];
          end
        end
        gpio_pkg::SEL_EXTERNAL_FUNCTION_CONTROL: begin
          if (q.wlane) begin
            d.control = q.wbyte[1:0];
          end
        end
        gpio_pkg::SEL_NONE: begin
          // Refused address still answers, so the master never hangs
          d.bresp = gpio_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Address and data channels reopen only after the response is taken
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end

    // Read data are captured at the address handshake; later pin changes wait for the next read
    if (q.arready && arvalid) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rdata = {24'h00_0000, read_byte};
      d.rresp = read_hit ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end

    // Wide port pins: direction bit alone decides the driver
    d.wide_drive = d.wide_data;
    d.wide_enable = d.wide_dir;

    // Narrow port pins: plain I/O unless an alternate function owns the pin
    d.narrow_drive = d.narrow_data;
    d.narrow_enable = d.narrow_dir;
    if (q.select[gpio_pkg::SELECT_PULSE_ONE_BIT]) begin
      d.narrow_drive[0] = pulse_output_one;
      d.narrow_enable[0] = 1'b1;
    end

    if (q.select[gpio_pkg::SELECT_PULSE_TWO_BIT]) begin
      d.narrow_drive[1] = pulse_output_two;
      d.narrow_enable[1] = 1'b1;
    end

    if (irq_mode) begin
      // Pin held as input even if software breaks the direction setting
      d.narrow_drive[gpio_pkg::NARROW_INTERRUPT_PIN] = 1'b0;
      d.narrow_enable[gpio_pkg::NARROW_INTERRUPT_PIN] = 1'b0;
    end else if (pulse_three_mode) begin
      d.narrow_drive[gpio_pkg::NARROW_PULSE_THREE_PIN] = pulse_output_three;
      d.narrow_enable[gpio_pkg::NARROW_PULSE_THREE_PIN] = 1'b1;
    end
    if (pulse_four_mode) begin
      d.narrow_drive[gpio_pkg::NARROW_PULSE_FOUR_PIN] = pulse_output_four;
      d.narrow_enable[gpio_pkg::NARROW_PULSE_FOUR_PIN] = 1'b1;
    end

    // Idle high so a deselected pin never looks like an active-low request
    d.irq_n = irq_mode ? narrow_level[gpio_pkg::NARROW_INTERRUPT_PIN] : 1'b1;
  end

  // Clock enable low freezes every field, handshakes included; reset still loads RESET_STATE
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RESET_STATE;
    end else if (ce) begin
      q <= d;
    end
  end

  // Every output is a register field
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rresp = q.rresp;
  assign rdata = q.rdata;
  assign wide_port_pin_drive = q.wide_drive;
  assign wide_port_pin_enable = q.wide_enable;
  assign narrow_port_pin_drive = q.narrow_drive;
  assign narrow_port_pin_enable = q.narrow_enable;
  assign external_interrupt_line_four_n = q.irq_n;

endmodule // gpio_ports

//--- logic/pin_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 12
) (
  input wire logic aclk,
  input wire logic ce,
  input wire logic aresetn,
  pin_sync_if.syncer pins
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } state_type;

  state_type q;
  state_type d;

  // First stage feeds only the second stage
  always_comb begin
    d.first = pins.raw;
    d.second = q.first;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign pins.synced = q.second;

endmodule // pin_sync

//--- logic/pin_sync_if.sv
// Carrier between the pin synchroniser and the port logic
`timescale 1ns/1ps
interface pin_sync_if #(parameter int WIDTH = 12);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport syncer (input raw, output synced);
  modport user (output raw, input synced);
endinterface
